// ===== src/qdac_params.svh
// Constants for the quad converter serial command decoder
`ifndef QDAC_PARAMS_SVH
`define QDAC_PARAMS_SVH
`define QDAC_WORD_BITS 24
`define QDAC_LOAD_ALL_POS 21
`define QDAC_LOAD_SINGLE_POS 20
`define QDAC_SEL_HI_POS 18
`define QDAC_SEL_LO_POS 17
`define QDAC_PD_FLAG_POS 16
`define QDAC_MODE_HI_POS 15
`define QDAC_MODE_LO_POS 14
`define QDAC_REF_HI_POS 15
`define QDAC_REF_LO_POS 12
`define QDAC_SEL_BCAST 2'h2
`define QDAC_REF_CODE_DEFAULT 4'h0
`define QDAC_REF_CODE_ON 4'h1
`define QDAC_REF_CODE_OFF 4'h2
`define QDAC_DATA_RESET 16'h0000
`define QDAC_REFON_RESET 1'b1
`define QDAC_BCNT_RESET 5'h00
`endif

// ===== src/qdac_pkg.sv
// Types for the quad converter serial command decoder
package qdac_pkg;
    // Channel output state
    typedef enum logic [1:0] {
        QDAC_PD_NORMAL,
        QDAC_PD_1K,
        QDAC_PD_100K,
        QDAC_PD_HIZ
    } qdac_pd_t;
    // Reference control mode
    typedef enum logic [1:0] {
        QDAC_REF_AUTO,
        QDAC_REF_FORCE_ON,
        QDAC_REF_FORCE_OFF
    } qdac_ref_t;
endpackage

// ===== src/qdac_decoder.sv
// Serial command decoder with channel buffers, converter registers and reference control
// Operation
// RULE1 - Mode bits 11 select high-impedance power-down
// RULE2 - Single-load writes buffer, updates that channel
// RULE3 - Broadcast power-down applies to all channels
// RULE4 - Broadcast data loads and updates all channels
// RULE5 - Reference code 0001 forces reference on
// RULE6 - Reference code 0010 forces reference off
// RULE7 - Reference code 0000 restores automatic mode
// RULE8 - Reset leaves reference in automatic mode
// RULE9 - Auto mode: all powered down, reference off
// RULE10 - Auto mode: data write powers reference up
// RULE11 - Forced on keeps reference always powered
// RULE12 - Forced off keeps reference always down
// RULE13 - Data write loads and leaves power-down
// RULE14 - Updates happen on 24th falling edge
// RULE15 - Mode 01 is 1k, 10 is 100k
// RULE16 - Load bits select store, or store-and-update-all
// RULE17 - Register contents kept during power-down
// RULE18 - Host sends most significant bit first
// RULE19 - Frame holds one 24-bit word
// Word layout, first bit on the wire at the top:
//   [21] load_all_bit, [20] load_single_bit
//   [18:17] channel select; 10 with both load bits is broadcast
//   [16] power_down_flag; [15:14] power mode when set
//   [15:12] reference code when the word is a reference command
//   [15:0] converter code for data writes
// Latency from the 24th link clock fall to the outputs is about
// three system clocks: two synchroniser stages, then the register; edge detect adds none.
`include "qdac_params.svh"
module qdac_decoder
    import qdac_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int DATA_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdin,
    output logic [NUM_CH*DATA_W-1:0] dac_code,
    output logic [2*NUM_CH-1:0] ch_pd_mode,
    output logic ref_enable,
    output logic [1:0] ref_mode,
    output logic update_strobe
);
    // Elaboration check: word layout fixes four channels of 16 bits
    // Other sizes would need a different word layout and select field
    if (NUM_CH != 4 || DATA_W != 16) begin : g_bad_size
        $error("qdac_decoder serves four channels of 16 bits only");
    end

    // Pin synchronisers, two stages each
    // Frame select, link clock and data all come from another domain
    logic [1:0] sync_n_s;
    logic [1:0] sclk_s;
    logic [1:0] sdin_s;
    logic sclk_d; // Previous synchronised clock level

    // Shift state
    // Count runs from 0 to 24 and stops; 24 means the word was taken
    logic [`QDAC_WORD_BITS-1:0] shreg; // Incoming word, MSB first
    logic [4:0] bcnt; // Bits received in frame
    logic [`QDAC_WORD_BITS-1:0] next_shreg;
    logic [4:0] next_bcnt;

    // Channel state
    // Buffered state waits for a load; applied state drives the outputs
    logic [DATA_W-1:0] buf_q [NUM_CH]; // Input buffers
    logic [DATA_W-1:0] dac_q [NUM_CH]; // Converter registers
    qdac_pd_t pdbuf_q [NUM_CH]; // Buffered power state
    qdac_pd_t pd_q [NUM_CH]; // Applied power state
    qdac_ref_t refm_q; // Reference mode
    logic refon_q; // Reference powered
    logic upd_q; // Update strobe
    logic [DATA_W-1:0] next_buf [NUM_CH];
    logic [DATA_W-1:0] next_dac [NUM_CH];
    qdac_pd_t next_pdbuf [NUM_CH];
    qdac_pd_t next_pd [NUM_CH];
    qdac_ref_t next_refm;
    logic next_refon;
    logic next_upd;

    // Edge detection on synchronised pins
    // Falls only count while frame select is low
    logic fall; // Falling serial clock edge
    logic active; // Frame select low
    assign fall = sclk_d & ~sclk_s[1];
    assign active = ~sync_n_s[1];

    // Mode bits to power state
    // Mode 00 with the flag set means no power-down
    function automatic qdac_pd_t pd_decode(input logic [1:0] m);
        qdac_pd_t r;
        case (m)
            2'h1: r = QDAC_PD_1K; // RULE15
            2'h2: r = QDAC_PD_100K; // RULE15
            2'h3: r = QDAC_PD_HIZ; // RULE1
            default: r = QDAC_PD_NORMAL;
        endcase
        return r;
    endfunction

    // Synchroniser registers; only stage two is read by logic
    // Link clock stages reset high, the level the host parks it at,
    // so leaving reset never shows a spurious edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_n_s <= 2'h3;
            sclk_s <= 2'h3;
            sdin_s <= 2'h0;
            sclk_d <= 1'b1;
        end else begin
            sync_n_s <= {sync_n_s[0], sync_n};
            sclk_s <= {sclk_s[0], sclk};
            sdin_s <= {sdin_s[0], sdin};
            sclk_d <= sclk_s[1];
        end
    end

    // Shifter next state: one bit per falling edge while framed
    // Raising frame select early drops the partial word; falls after
    // the 24th bit are ignored until the frame closes
    always_comb begin
        next_shreg = shreg;
        next_bcnt = bcnt;
        if (!active) begin
            next_bcnt = `QDAC_BCNT_RESET; // RULE19
        end else if (fall && bcnt < 5'(`QDAC_WORD_BITS)) begin
            next_shreg = {shreg[`QDAC_WORD_BITS-2:0], sdin_s[1]}; // RULE18
            next_bcnt = bcnt + 5'h01;
        end
    end

    // Shifter registers
    // Shift register is not cleared per frame; the count gates a word
    always_ff @(posedge mclk) begin
        if (rst) begin
            shreg <= '0;
            bcnt <= `QDAC_BCNT_RESET;
        end else begin
            shreg <= next_shreg;
            bcnt <= next_bcnt;
        end
    end

    // Word decode, acts once when the 24th falling edge lands
    // The last bit is merged straight from the synchroniser so the
    // word acts on the same edge that takes its final bit
    logic word_done;
    logic [`QDAC_WORD_BITS-1:0] w; // Complete word
    assign word_done = active && fall && bcnt == 5'(`QDAC_WORD_BITS - 1); // RULE14
    assign w = {shreg[`QDAC_WORD_BITS-2:0], sdin_s[1]};

    // Command decode: next buffers, converter registers, power states
    // and reference mode; everything holds unless a whole word lands
    always_comb begin
        logic ld_all;
        logic ld_one;
        logic pdf;
        logic [1:0] sel;
        logic bcast;
        logic refcmd;
        logic any_up;
        logic all_down;
        qdac_pd_t pdv;
        ld_all = w[`QDAC_LOAD_ALL_POS];
        ld_one = w[`QDAC_LOAD_SINGLE_POS];
        pdf = w[`QDAC_PD_FLAG_POS];
        sel = {w[`QDAC_SEL_HI_POS], w[`QDAC_SEL_LO_POS]};
        bcast = ld_all && ld_one && sel == `QDAC_SEL_BCAST;
        // Reference command is the flag-set form with mode bits 00; other
        // mode bits in that form are a buffer-only power-down of channel 0
        refcmd = !ld_all && !ld_one && sel == 2'h0 && pdf
            && w[`QDAC_MODE_HI_POS:`QDAC_MODE_LO_POS] == 2'h0; // RULE5
        pdv = pdf ? pd_decode(w[`QDAC_MODE_HI_POS:`QDAC_MODE_LO_POS]) : QDAC_PD_NORMAL;
        // Reference wake and sleep conditions, found in the loop below
        any_up = 1'b0;
        all_down = 1'b1;
        next_refm = refm_q;
        next_upd = 1'b0;
        // By default every channel keeps its state
        for (int i = 0; i < NUM_CH; i++) begin
            next_buf[i] = buf_q[i];
            next_dac[i] = dac_q[i];
            next_pdbuf[i] = pdbuf_q[i];
            next_pd[i] = pd_q[i];
        end
        // Nothing changes until a complete word arrives
        if (word_done) begin
            if (refcmd) begin
                // Reference command; other codes leave the mode as is
                case (w[`QDAC_REF_HI_POS:`QDAC_REF_LO_POS])
                    `QDAC_REF_CODE_ON: next_refm = QDAC_REF_FORCE_ON; // RULE5
                    `QDAC_REF_CODE_OFF: next_refm = QDAC_REF_FORCE_OFF; // RULE6
                    `QDAC_REF_CODE_DEFAULT: next_refm = QDAC_REF_AUTO; // RULE7
                    default: next_refm = refm_q;
                endcase
            end else if (bcast) begin
                // Broadcast: same setting to all, update together
                for (int i = 0; i < NUM_CH; i++) begin
                    next_pdbuf[i] = pdv; // RULE3
                    next_pd[i] = pdv; // RULE3
                    // Data broadcast also returns every channel to normal
                    if (!pdf) begin
                        next_buf[i] = w[DATA_W-1:0]; // RULE4
                        next_dac[i] = w[DATA_W-1:0]; // RULE4
                    end
                end
                next_upd = 1'b1; // RULE14
            end else begin
                // Addressed store into buffer
                next_pdbuf[sel] = pdv; // RULE16
                // Only data words replace the stored code
                if (!pdf) begin
                    next_buf[sel] = w[DATA_W-1:0]; // RULE16
                end
                if (ld_all) begin
                    // Update every channel from its buffer
                    for (int i = 0; i < NUM_CH; i++) begin
                        next_pd[i] = next_pdbuf[i]; // RULE16
                        // A powered-down channel keeps its converter register
                        if (next_pdbuf[i] == QDAC_PD_NORMAL) begin
                            next_dac[i] = next_buf[i]; // RULE17
                        end
                    end
                    next_upd = 1'b1; // RULE14
                end else if (ld_one) begin
                    // Update the addressed channel alone
                    next_pd[sel] = pdv; // RULE2
                    // Converter register kept while the channel is powered down
                    if (!pdf) begin
                        next_dac[sel] = w[DATA_W-1:0]; // RULE13
                    end
                    next_upd = 1'b1; // RULE2
                end
            end
        end
        // All down, or a channel leaving power-down, steers auto mode
        for (int i = 0; i < NUM_CH; i++) begin
            if (next_pd[i] == QDAC_PD_NORMAL) begin
                all_down = 1'b0;
                if (pd_q[i] != QDAC_PD_NORMAL) begin
                    any_up = 1'b1; // RULE10
                end
            end
        end
        // Reference power from mode and channel state
        // Forced modes win; auto follows the channel power states
        case (next_refm)
            QDAC_REF_FORCE_ON: next_refon = 1'b1; // RULE11
            QDAC_REF_FORCE_OFF: next_refon = 1'b0; // RULE12
            default: begin
                if (all_down) begin
                    next_refon = 1'b0; // RULE9
                end else if (any_up) begin
                    next_refon = 1'b1; // RULE10
                end else begin
                    // Leaving a forced mode for auto turns the reference on
                    next_refon = refon_q | (refm_q != QDAC_REF_AUTO);
                end
            end
        endcase
    end

    // Channel and reference registers
    // Reset state matches the automatic reference command
    always_ff @(posedge mclk) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                buf_q[i] <= `QDAC_DATA_RESET;
                dac_q[i] <= `QDAC_DATA_RESET;
                pdbuf_q[i] <= QDAC_PD_NORMAL;
                pd_q[i] <= QDAC_PD_NORMAL;
            end
            refm_q <= QDAC_REF_AUTO; // RULE8
            refon_q <= `QDAC_REFON_RESET; // RULE8
            upd_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                buf_q[i] <= next_buf[i];
                dac_q[i] <= next_dac[i];
                pdbuf_q[i] <= next_pdbuf[i];
                pd_q[i] <= next_pd[i];
            end
            refm_q <= next_refm;
            refon_q <= next_refon;
            upd_q <= next_upd;
        end
    end

    // Outputs straight from registers
    // Plain wiring of register values, no logic in the path
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            dac_code[i*DATA_W +: DATA_W] = dac_q[i];
            ch_pd_mode[2*i +: 2] = pd_q[i];
        end
        ref_enable = refon_q;
        ref_mode = refm_q;
        update_strobe = upd_q;
    end
endmodule

// ===== testbench/qdac_decoder_monitor.sv
// Port assertions for the quad converter command decoder
module qdac_decoder_monitor
    import qdac_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int DATA_W = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdin,
    input wire logic [NUM_CH*DATA_W-1:0] dac_code,
    input wire logic [2*NUM_CH-1:0] ch_pd_mode,
    input wire logic ref_enable,
    input wire logic [1:0] ref_mode,
    input wire logic update_strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // High while every channel is powered down
    logic all_down;
    always_comb begin
        all_down = 1'b1;
        for (int i = 0; i < NUM_CH; i++) begin
            if (ch_pd_mode[2*i +: 2] == 2'h0) all_down = 1'b0;
        end
    end
    reset_state_a: assert property (
        $fell(rst) |-> ref_enable && ref_mode == 2'h0 && dac_code == '0 && !update_strobe)
        else $error("outputs not at reset state");
    strobe_single_a: assert property (update_strobe |=> !update_strobe)
        else $error("update strobe longer than one cycle");
    code_on_update_a: assert property (!$stable(dac_code) |-> update_strobe)
        else $error("converter code changed without update");
    pd_on_update_a: assert property (!$stable(ch_pd_mode) |-> update_strobe)
        else $error("power state changed without update");
    forced_on_a: assert property (ref_mode == 2'h1 |-> ref_enable)
        else $error("forced-on reference is off");
    forced_off_a: assert property (ref_mode == 2'h2 |-> !ref_enable)
        else $error("forced-off reference is on");
    auto_off_a: assert property (
        (ref_mode == 2'h0 && all_down) [*2] |-> !ref_enable)
        else $error("reference on with all channels down");
    auto_on_a: assert property (
        (ref_mode == 2'h0 && $fell(all_down)) |-> ##[0:1] ref_enable)
        else $error("reference stayed off after channel wake");
endmodule
bind qdac_decoder qdac_decoder_monitor #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) u_mon (
    .mclk(mclk), .rst(rst), .sync_n(sync_n), .sclk(sclk), .sdin(sdin),
    .dac_code(dac_code), .ch_pd_mode(ch_pd_mode), .ref_enable(ref_enable),
    .ref_mode(ref_mode), .update_strobe(update_strobe));

// ===== testbench/qdac_host_model.sv
// Serial host that sends command frames to the decoder
module qdac_host_model (
    output logic sync_n,
    output logic sclk,
    output logic sdin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: frame deselected, link clock parked high
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        sdin = 1'b0;
    end
    // Send the top nbits of a word, taken on falling edges
    task automatic send(input logic [23:0] word, input int nbits);
        sync_n = 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            sdin = word[i];
            #100 sclk = 1'b0;
            #100 sclk = 1'b1;
        end
        sync_n = 1'b1;
        // Released line shows a changed level
        sdin = ~sdin;
        #400;
    endtask
endmodule

// ===== testbench/tb_quad_dac_serial_command_decoder.sv
// Self-checking bench for the quad converter command decoder
module tb_quad_dac_serial_command_decoder;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst, sync_n, sclk, sdin, ref_enable, update_strobe;
    logic [63:0] dac_code;
    logic [7:0] ch_pd_mode;
    logic [1:0] ref_mode;
    int mismatches, samples_checked, cycles, strobes;
    qdac_decoder u_qdac_decoder (.mclk(mclk), .rst(rst), .sync_n(sync_n), .sclk(sclk),
        .sdin(sdin), .dac_code(dac_code), .ch_pd_mode(ch_pd_mode), .ref_enable(ref_enable),
        .ref_mode(ref_mode), .update_strobe(update_strobe));
    qdac_host_model u_qdac_host_model (.sync_n(sync_n), .sclk(sclk), .sdin(sdin));
    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Count strobes and cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (update_strobe === 1'b1) strobes++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One frame, started just after a system clock edge
    task automatic send(input logic [23:0] w, input int nbits = 24);
        @(posedge mclk);
        #1;
        u_qdac_host_model.send(w, nbits);
    endtask
    task automatic t_reset();
        @(posedge mclk) #1 rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(dac_code, 64'h0);
        chk(64'({ch_pd_mode, ref_mode, ref_enable}), 64'h1);
    endtask
    task automatic t_single();
        int s0;
        s0 = strobes;
        send(24'h101234);
        chk(dac_code, 64'h1234);
        chk(64'(strobes - s0), 64'h1);
        send(24'h10ffff, 12);
        chk(dac_code, 64'h1234);
    endtask
    task automatic t_store_all();
        send(24'h021111);
        send(24'h042222);
        chk(dac_code, 64'h1234);
        send(24'h263333);
        chk(dac_code, 64'h3333_2222_1111_1234);
    endtask
    task automatic t_pd();
        send(24'h114000);
        send(24'h138000);
        send(24'h15c000);
        chk(64'(ch_pd_mode), 64'h39);
        chk(dac_code, 64'h3333_2222_1111_1234);
        send(24'h17c000);
        chk(64'({ch_pd_mode, ref_enable}), 64'h1f2);
        send(24'h10abcd);
        chk(64'({ch_pd_mode, ref_enable}), 64'h1f1);
        chk(dac_code, 64'h3333_2222_1111_abcd);
    endtask
    task automatic t_force_on();
        send(24'h011000);
        chk(64'({ref_mode, ref_enable}), 64'h3);
        send(24'h35c000);
        chk(64'({ch_pd_mode, ref_enable}), 64'h1ff);
    endtask
    task automatic t_force_off();
        send(24'h012000);
        chk(64'({ref_mode, ref_enable}), 64'h4);
        send(24'h345555);
        chk(dac_code, 64'h5555_5555_5555_5555);
        chk(64'({ch_pd_mode, ref_enable}), 64'h0);
        send(24'h010000);
        chk(64'({ref_mode, ref_enable}), 64'h1);
    endtask
    task automatic t_pd_store();
        int s0;
        s0 = strobes;
        send(24'h014000);
        send(24'h038000);
        chk(64'(ch_pd_mode), 64'h0);
        chk(64'({ref_mode, ref_enable}), 64'h1);
        chk(64'(strobes - s0), 64'h0);
        send(24'h27c000);
        chk(64'(ch_pd_mode), 64'hc9);
        chk(dac_code, 64'h5555_5555_5555_5555);
        chk(64'(strobes - s0), 64'h1);
    endtask
    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        t_reset();
        t_single();
        t_store_all();
        t_pd();
        t_force_on();
        t_force_off();
        t_pd_store();
        t_reset();
        stop_test();
    end
endmodule
